/* File: brw_boot_ctrl.sv */
`timescale 1ns/1ps
`include "brw_params.svh"
module brw_boot_ctrl
  import brw_pkg::*;
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_hard_reset_n,
  input  wire brw_pkg::brw_mode_pins_t i_boot_select_pins,
  input  wire logic                   i_receiver_reset,
  input  wire logic                   i_soft_cpu_reset,
  input  wire logic                   i_soft_device_reset,
  input  wire brw_pkg::brw_load_stat_t i_load_stat,
  input  wire logic                   i_usb_load_done,
  input  wire logic                   i_spi_flash_ok,
  input  wire logic                   i_watchdog_slow_clock_in,
  input  wire logic                   i_use_ext_slow_clk,
  input  wire brw_pkg::brw_wd_ctrl_t  i_wd_ctrl,
  input  wire logic                   i_sensor_reset_force,
  input  wire logic [15:0]            i_sensor_release_dly,
  input  wire logic                   i_sensor_shutdown,
  input  wire logic                   i_sensor_clk_en,
  output logic [2:0]                  o_boot_src,
  output logic                        o_load_start,
  output logic                        o_cpu_run,
  output logic                        o_pc_clear,
  output logic                        o_fw_invalid,
  output logic                        o_io_hiz,
  output logic                        o_receiver_core_reset,
  output logic                        o_wd_irq,
  output logic                        o_wd_wake,
  output logic                        o_sensor_reset_out_n,
  output logic                        o_sensor_shutdown_out,
  output logic                        o_sensor_clk
);
  import brw_pkg::*;

  brw_state_t state;
  brw_src_t   src;
  logic       fallback;
  logic       full_rst;
  logic       rst_seen;
  logic       hard_q;
  logic       slow_ext_q;
  logic       slow_ext_qq;
  logic       slow_ext_prev;
  logic [11:0] slow_div;
  logic       slow_tick;
  logic       wd_irq;
  logic       wd_wake;
  logic       wd_cpu_rst;
  logic [15:0] sensor_cnt;
  logic [7:0] mclk_div;

  localparam logic [11:0] SLOW_DIV =
    12'(`BRW_SYS_CLK_HZ / `BRW_SLOW_CLK_HZ - 1);

  // Floating pin reads as undriven; three levels per pin
  function automatic logic [1:0] pin_state(input logic drv, input logic lvl);
    pin_state = !drv ? `BRW_PIN_FLOAT : (lvl ? `BRW_PIN_HIGH : `BRW_PIN_LOW);
  endfunction

  // ----------------------------------------------------------------
  // Full reset: hard pin or whole-device soft reset
  // ----------------------------------------------------------------
  assign full_rst = !i_hard_reset_n || i_soft_device_reset;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hard_q   <= 1'b1;
      o_io_hiz <= 1'b1;
    end
    else
    begin
      hard_q   <= full_rst;
      o_io_hiz <= full_rst;
    end
  end

  // ----------------------------------------------------------------
  // Boot source decode, caught on release
  // ----------------------------------------------------------------
  logic [5:0] pat;
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pin
      assign pat[2*g +: 2] = pin_state(i_boot_select_pins.drive[g], i_boot_select_pins.level[g]);
    end
  endgenerate

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      src      <= BRW_SRC_NONE;
      fallback <= 1'b0;
      rst_seen <= 1'b0;
    end
    else if (full_rst)
      rst_seen <= 1'b1;
    else if (rst_seen || state == BRW_ST_RESET)
    begin
      rst_seen <= 1'b0;
      // Sampled on release and on every clock in BRW_ST_RESET; later pin changes are ignored
      case (pat)
        `BRW_PAT_USB:      begin src <= BRW_SRC_USB; fallback <= 1'b0; end
        `BRW_PAT_I2C_ONLY: begin src <= BRW_SRC_I2C; fallback <= 1'b0; end
        `BRW_PAT_I2C_FB:   begin src <= BRW_SRC_I2C; fallback <= 1'b1; end
        `BRW_PAT_SPI_FB:   begin src <= BRW_SRC_SPI; fallback <= 1'b1; end
        default:           begin src <= BRW_SRC_NONE; fallback <= 1'b0; end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state        <= BRW_ST_RESET;
      o_boot_src   <= BRW_SRC_NONE;
      o_load_start <= 1'b0;
      o_cpu_run    <= 1'b0;
      o_fw_invalid <= 1'b1;
    end
    else if (full_rst)
    begin
      state        <= BRW_ST_RESET;
      o_boot_src   <= BRW_SRC_NONE;
      o_load_start <= 1'b0;
      o_cpu_run    <= 1'b0;
      o_fw_invalid <= 1'b1;
    end
    else
    begin
      o_load_start <= 1'b0;
      case (state)
        BRW_ST_RESET:
        begin
          if (!hard_q)
          begin
            // Unknown pattern: USB is the safe default
            o_boot_src   <= (src == BRW_SRC_NONE) ? BRW_SRC_USB : src;
            o_load_start <= 1'b1;
            state        <= (src == BRW_SRC_USB || src == BRW_SRC_NONE) ? BRW_ST_USBWT : BRW_ST_LOAD;
          end
        end
        BRW_ST_LOAD:
        begin
          // SPI boot needs a supported flash size
          if (i_load_stat.load_done && (src != BRW_SRC_SPI || i_spi_flash_ok))
          begin
            state        <= BRW_ST_RUN;
            o_cpu_run    <= 1'b1;
            o_fw_invalid <= 1'b0;
          end
          else if (i_load_stat.load_fail || i_load_stat.load_done)
          begin
            if (fallback)
            begin
              o_boot_src   <= BRW_SRC_USB;
              o_load_start <= 1'b1;
              state        <= BRW_ST_USBWT;
            end
            else
              state <= BRW_ST_HALT;
          end
        end
        BRW_ST_USBWT:
        begin
          if (i_usb_load_done)
          begin
            state        <= BRW_ST_RUN;
            o_cpu_run    <= 1'b1;
            o_fw_invalid <= 1'b0;
          end
        end
        BRW_ST_RUN:
          o_cpu_run <= 1'b1;
        BRW_ST_HALT:
          o_cpu_run <= 1'b0;
        default:
          state <= BRW_ST_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // CPU-only reset keeps firmware
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_pc_clear <= 1'b1;
    else
      o_pc_clear <= full_rst || i_soft_cpu_reset || wd_cpu_rst;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_receiver_core_reset <= 1'b1;
    else
      o_receiver_core_reset <= i_receiver_reset;
  end

  // ----------------------------------------------------------------
  // Slow clock: external pin or internal divider
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      slow_ext_q    <= 1'b0;
      slow_ext_qq   <= 1'b0;
      slow_ext_prev <= 1'b0;
      slow_div      <= 12'h000;
    end
    else
    begin
      slow_ext_q    <= i_watchdog_slow_clock_in;
      slow_ext_qq   <= slow_ext_q;
      slow_ext_prev <= slow_ext_qq;
      slow_div      <= (slow_div == SLOW_DIV) ? 12'h000 : slow_div + 12'h001;
    end
  end

  assign slow_tick = i_use_ext_slow_clk ? (slow_ext_qq && !slow_ext_prev) : (slow_div == SLOW_DIV);

  brw_watchdog u_wd
  (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_slow_tick (slow_tick),
    .i_ctrl      (i_wd_ctrl),
    .o_irq       (wd_irq),
    .o_wake      (wd_wake),
    .o_cpu_reset (wd_cpu_rst)
  );

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_wd_irq  <= 1'b0;
      o_wd_wake <= 1'b0;
    end
    else
    begin
      o_wd_irq  <= wd_irq;
      o_wd_wake <= wd_wake;
    end
  end

  // ----------------------------------------------------------------
  // Sensor control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sensor_cnt           <= 16'h0000;
      o_sensor_reset_out_n <= 1'b0;
    end
    else if (full_rst)
    begin
      sensor_cnt           <= 16'h0000;
      o_sensor_reset_out_n <= 1'b0;
    end
    else
    begin
      // Delay counted in slow ticks, so firmware sets it in ~30 us steps
      if (slow_tick && sensor_cnt != i_sensor_release_dly)
        sensor_cnt <= sensor_cnt + 16'h0001;
      o_sensor_reset_out_n <= !i_sensor_reset_force
                              && sensor_cnt == i_sensor_release_dly;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_sensor_shutdown_out <= 1'b0;
    else
      o_sensor_shutdown_out <= i_sensor_shutdown;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mclk_div     <= 8'h00;
      o_sensor_clk <= 1'b0;
    end
    else if (!i_sensor_clk_en)
    begin
      mclk_div     <= 8'h00;
      o_sensor_clk <= 1'b0;
    end
    else if (mclk_div == `BRW_SENSOR_CLK_DIV - 8'h01)
    begin
      // Test clock only; jitter is not production grade
      mclk_div     <= 8'h00;
      o_sensor_clk <= !o_sensor_clk;
    end
    else
      mclk_div <= mclk_div + 8'h01;
  end
endmodule

/* File: brw_boot_ctrl_assertions.sv */
`timescale 1ns/1ps
module brw_boot_ctrl_assertions
  import brw_pkg::*;
(
  input wire logic                    i_sys_clk,
  input wire logic                    i_rst,
  input wire logic                    i_hard_reset_n,
  input wire brw_pkg::brw_mode_pins_t i_boot_select_pins,
  input wire logic                    i_receiver_reset,
  input wire logic                    i_soft_cpu_reset,
  input wire logic                    i_soft_device_reset,
  input wire brw_pkg::brw_load_stat_t i_load_stat,
  input wire brw_pkg::brw_wd_ctrl_t   i_wd_ctrl,
  input wire logic [2:0]              o_boot_src,
  input wire logic                    o_load_start,
  input wire logic                    o_cpu_run,
  input wire logic                    o_pc_clear,
  input wire logic                    o_fw_invalid,
  input wire logic                    o_io_hiz,
  input wire logic                    o_receiver_core_reset,
  input wire logic                    o_wd_irq,
  input wire logic                    o_wd_wake
);
  // ----------------------------------------
  // Boot, reset and watchdog checks
  // ----------------------------------------
  logic full_rst;
  assign full_rst = !i_hard_reset_n || i_soft_device_reset;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_spi_fail;
    o_boot_src == BRW_SRC_SPI && i_load_stat.load_fail && !full_rst;
  endsequence
  sequence s_usb_retry;
    o_boot_src == BRW_SRC_USB && o_load_start;
  endsequence
  sequence s_i2c_only_fail;
    i_boot_select_pins.drive == 3'h4 && i_boot_select_pins.level[2] && o_boot_src == BRW_SRC_I2C
      && i_load_stat.load_fail && !full_rst;
  endsequence
  a_hold_hiz: assert property (!i_hard_reset_n |=> o_io_hiz)
    else $error("io not tristated in hard reset");
  a_recv_reset: assert property (i_receiver_reset |=> o_receiver_core_reset)
    else $error("receiver core not reset");
  a_src_locked: assert property (o_cpu_run && !full_rst |=> $stable(o_boot_src))
    else $error("boot source moved while running");
  a_pc_on_soft: assert property (i_soft_cpu_reset |=> o_pc_clear)
    else $error("program counter not cleared");
  a_fw_kept: assert property (i_soft_cpu_reset && !full_rst && !o_fw_invalid |=> !o_fw_invalid)
    else $error("firmware lost on cpu reset");
  a_dev_reset: assert property (i_soft_device_reset |=> o_io_hiz && o_fw_invalid && !o_cpu_run)
    else $error("device reset not full");
  a_wd_quiet: assert property (!i_wd_ctrl.enable [*3] |=> !o_wd_irq && !o_wd_wake)
    else $error("disabled watchdog fired");
  a_spi_fallback: assert property (s_spi_fail |=> s_usb_retry)
    else $error("no usb fallback after flash failure");
  a_i2c_halt: assert property (s_i2c_only_fail |=> (!o_cpu_run && !o_load_start) [*8])
    else $error("processor ran after failed load");
endmodule

/* File: brw_boot_mem_model.sv */
`timescale 1ns/1ps
module brw_boot_mem_model
  import brw_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_load_start,
  input  wire logic [2:0]        i_boot_src,
  input  wire logic              i_fail,
  input  wire logic              i_slow,
  output brw_pkg::brw_load_stat_t o_load_stat,
  output logic                   o_usb_done
);
  // ----------------------------------------
  // Boot memories and host download
  // ----------------------------------------
  logic [2:0] src;
  initial
  begin
    o_load_stat = '0;
    o_usb_done = 1'b0;
  end
  always
  begin
    @(posedge i_sys_clk iff i_load_start === 1'b1);
    src = i_boot_src;
    repeat (i_slow ? 24 : 3) @(negedge i_sys_clk);
    if (src == BRW_SRC_USB)
      o_usb_done = 1'b1;
    else if (i_fail)
      o_load_stat.load_fail = 1'b1;
    else
      o_load_stat.load_done = 1'b1;
    // One answer per load, one cycle wide
    @(negedge i_sys_clk);
    o_load_stat = '0;
    o_usb_done = 1'b0;
  end
endmodule

/* File: brw_params.svh */
`ifndef BRW_PARAMS_SVH
`define BRW_PARAMS_SVH

// Boot-select pin states, two bits each
`define BRW_PIN_LOW          2'h0
`define BRW_PIN_HIGH         2'h1
`define BRW_PIN_FLOAT        2'h2
// Patterns, pin 2 in the top two bits
`define BRW_PAT_USB          6'h25
`define BRW_PAT_I2C_ONLY     6'h1a
`define BRW_PAT_I2C_FB       6'h26
`define BRW_PAT_SPI_FB       6'h09
// Slow clock and timing
`define BRW_SLOW_CLK_HZ      32768
`define BRW_SYS_CLK_HZ       100000000
`define BRW_WD_LIMIT_RESET   16'h8000
`define BRW_SENSOR_DLY_RESET 16'h0020
`define BRW_SENSOR_CLK_DIV   8'h04
`define BRW_SPI_FLASH_16M    3'h4
`define BRW_SPI_FLASH_8M     3'h2
`define BRW_SPI_FLASH_4M     3'h1
`endif

/* File: brw_pkg.sv */
package brw_pkg;
  typedef enum logic [2:0] {
    BRW_SRC_NONE = 3'b000,
    BRW_SRC_USB  = 3'b001,
    BRW_SRC_I2C  = 3'b010,
    BRW_SRC_SPI  = 3'b011
  } brw_src_t;

  typedef enum logic [2:0] {
    BRW_ST_RESET  = 3'b000,
    BRW_ST_LOAD   = 3'b001,
    BRW_ST_RUN    = 3'b010,
    BRW_ST_HALT   = 3'b011,
    BRW_ST_USBWT  = 3'b100
  } brw_state_t;

  typedef struct packed {
    logic [2:0] drive;
    logic [2:0] level;
  } brw_mode_pins_t;

  typedef struct packed {
    logic        load_done;
    logic        load_fail;
  } brw_load_stat_t;

  typedef struct packed {
    logic        enable;
    logic        kick;
    logic [15:0] limit;
    logic        irq_en;
    logic        wake_en;
    logic        reset_en;
  } brw_wd_ctrl_t;
endpackage

/* File: brw_watchdog.sv */
`timescale 1ns/1ps
`include "brw_params.svh"
module brw_watchdog
  import brw_pkg::*;
(
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst,
  input  wire logic          i_slow_tick,
  input  wire brw_pkg::brw_wd_ctrl_t i_ctrl,
  output logic               o_irq,
  output logic               o_wake,
  output logic               o_cpu_reset
);
  logic [15:0] count;

  // ----------------------------------------------------------------
  // Counter on slow ticks
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      count <= 16'h0000;
    else if (!i_ctrl.enable || i_ctrl.kick)
      count <= 16'h0000;
    else if (i_slow_tick && count != i_ctrl.limit)
      count <= count + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Expiry actions, one pulse each
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_irq       <= 1'b0;
      o_wake      <= 1'b0;
      o_cpu_reset <= 1'b0;
    end
    else
    begin
      // Fires on the tick seen with the count one below the limit, even if a kick clears the count in that cycle
      o_irq       <= i_ctrl.enable && i_ctrl.irq_en && i_slow_tick
                     && count == i_ctrl.limit - 16'h0001;
      o_wake      <= i_ctrl.enable && i_ctrl.wake_en && i_slow_tick
                     && count == i_ctrl.limit - 16'h0001;
      o_cpu_reset <= i_ctrl.enable && i_ctrl.reset_en && i_slow_tick
                     && count == i_ctrl.limit - 16'h0001;
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import brw_pkg::*;
  logic i_sys_clk, i_rst, i_hard_reset_n, i_receiver_reset, i_soft_cpu_reset, i_soft_device_reset;
  logic i_usb_load_done, i_spi_flash_ok, i_watchdog_slow_clock_in, i_use_ext_slow_clk;
  logic i_sensor_reset_force, i_sensor_shutdown, i_sensor_clk_en, o_load_start, o_cpu_run;
  logic o_pc_clear, o_fw_invalid, o_io_hiz, o_receiver_core_reset, o_wd_irq, o_wd_wake;
  logic o_sensor_reset_out_n, o_sensor_shutdown_out, o_sensor_clk, fail_cmd, slow_cmd, clk_d;
  logic [15:0]    i_sensor_release_dly;
  logic [2:0]     o_boot_src;
  logic [2:0]     exp_q[$];
  brw_mode_pins_t i_boot_select_pins;
  brw_load_stat_t i_load_stat;
  brw_wd_ctrl_t   i_wd_ctrl;
  int             seed = 12338;
  int             failures = 0;
  int             compares = 0;
  int             irqs, wakes, toggles, pcs;
  brw_boot_ctrl DUT (.i_sys_clk, .i_rst, .i_hard_reset_n, .i_boot_select_pins, .i_receiver_reset,
    .i_soft_cpu_reset, .i_soft_device_reset, .i_load_stat, .i_usb_load_done, .i_spi_flash_ok,
    .i_watchdog_slow_clock_in, .i_use_ext_slow_clk, .i_wd_ctrl, .i_sensor_reset_force,
    .i_sensor_release_dly, .i_sensor_shutdown, .i_sensor_clk_en, .o_boot_src, .o_load_start,
    .o_cpu_run, .o_pc_clear, .o_fw_invalid, .o_io_hiz, .o_receiver_core_reset, .o_wd_irq,
    .o_wd_wake, .o_sensor_reset_out_n, .o_sensor_shutdown_out, .o_sensor_clk);
  brw_boot_mem_model u_mem (.i_sys_clk, .i_load_start(o_load_start), .i_boot_src(o_boot_src),
    .i_fail(fail_cmd), .i_slow(slow_cmd), .o_load_stat(i_load_stat), .o_usb_done(i_usb_load_done));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic wait_run(input logic run);
    for (int i = 0; i < 300 && o_cpu_run !== 1'b1; i++)
      cyc(1);
    cyc(10);
    chk("cpu run", 16'(run), 16'(o_cpu_run));
    chk("loads pending", 16'h0000, 16'(exp_q.size()));
  endtask
  // Pattern is {drive, level}; floating pins get random levels
  task automatic boot(input logic [5:0] pat, input logic fl, input logic ok, input logic [5:0] ex,
                      input logic run);
    i_boot_select_pins.drive = pat[5:3];
    i_boot_select_pins.level = pat[2:0] | (3'($random(seed)) & ~pat[5:3]);
    fail_cmd = fl;
    i_spi_flash_ok = ok;
    slow_cmd = 1'($random(seed));
    exp_q.push_back(ex[5:3]);
    if (ex[2:0] != 3'h0)
      exp_q.push_back(ex[2:0]);
    i_hard_reset_n = 1'b0;
    cyc(3);
    chk("io tristate", 16'h0001, 16'(o_io_hiz));
    i_hard_reset_n = 1'b1;
    cyc(2);
    chk("sensor reset held", 16'h0000, 16'(o_sensor_reset_out_n));
    wait_run(run);
    $display("boot test %h done", pat);
  endtask
  // ----------------------------------------
  // Stimulus and monitors
  // ----------------------------------------
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial
  begin
    i_watchdog_slow_clock_in = 1'b0;
    // Edges land on falling clock edges, away from the sampling edge
    forever #200 i_watchdog_slow_clock_in = ~i_watchdog_slow_clock_in;
  end
  always @(posedge i_sys_clk)
  begin
    if (o_load_start === 1'b1)
      chk("boot source", 16'(exp_q.size() ? exp_q.pop_front() : 3'h7), 16'(o_boot_src));
    if (o_wd_irq === 1'b1)
      irqs++;
    if (o_wd_wake === 1'b1)
      wakes++;
    if (o_pc_clear === 1'b1)
      pcs++;
    if (o_sensor_clk !== clk_d)
      toggles++;
    clk_d <= o_sensor_clk;
  end
  initial
  begin
    #400_000;
    failures++;
    wrap_up();
  end
  initial
  begin
    {i_rst, i_hard_reset_n, i_receiver_reset, i_soft_cpu_reset, i_soft_device_reset} = 5'b11000;
    {i_sensor_reset_force, i_sensor_shutdown, i_sensor_clk_en, i_use_ext_slow_clk} = 4'b0001;
    {fail_cmd, slow_cmd, i_spi_flash_ok} = 3'b001;
    i_boot_select_pins = '0;
    i_sensor_release_dly = 16'h0002;
    i_wd_ctrl = '0;
    cyc(5);
    i_rst = 1'b0;
    boot(6'h1b, 1'b0, 1'b1, 6'h08, 1'b1);
    boot(6'h12, 1'b1, 1'b1, 6'h11, 1'b1);
    boot(6'h24, 1'b1, 1'b1, 6'h10, 1'b0);
    boot(6'h24, 1'b0, 1'b1, 6'h10, 1'b1);
    boot(6'h29, 1'b1, 1'b1, 6'h19, 1'b1);
    boot(6'h29, 1'b0, 1'b0, 6'h19, 1'b1);
    boot(6'h29, 1'b0, 1'b1, 6'h18, 1'b1);
    boot(6'h00, 1'b0, 1'b1, 6'h08, 1'b1);
    i_soft_cpu_reset = 1'b1;
    cyc(2);
    chk("pc clear", 16'h0001, 16'(o_pc_clear));
    chk("fw kept", 16'h0000, 16'(o_fw_invalid));
    i_soft_cpu_reset = 1'b0;
    // Pins move while running; only the next full reset may take them
    i_boot_select_pins = {3'h5, 3'h1};
    cyc(10);
    exp_q.push_back(3'h3);
    i_soft_device_reset = 1'b1;
    cyc(2);
    chk("dev reset fw lost", 16'h0001, 16'(o_fw_invalid));
    i_soft_device_reset = 1'b0;
    wait_run(1'b1);
    $display("soft reset test done");
    i_receiver_reset = 1'b1;
    cyc(2);
    chk("receiver reset", 16'h0001, 16'(o_receiver_core_reset));
    i_receiver_reset = 1'b0;
    cyc(200);
    chk("receiver released", 16'h0000, 16'(o_receiver_core_reset));
    chk("sensor released", 16'h0001, 16'(o_sensor_reset_out_n));
    i_sensor_reset_force = 1'b1;
    i_sensor_shutdown = 1'b1;
    cyc(2);
    chk("sensor forced", 16'h0000, 16'(o_sensor_reset_out_n));
    chk("sensor shutdown", 16'h0001, 16'(o_sensor_shutdown_out));
    i_sensor_clk_en = 1'b1;
    cyc(4);
    toggles = 0;
    cyc(80);
    chk("sensor clock", 16'h0001, 16'(toggles >= 19 && toggles <= 21));
    $display("sensor test done");
    i_wd_ctrl = '{enable: 1'b1, kick: 1'b0, limit: 16'h0003, irq_en: 1'b1, wake_en: 1'b1, reset_en: 1'b1};
    irqs = 0;
    wakes = 0;
    pcs = 0;
    for (int i = 0; i < 1000 && irqs == 0; i++)
      cyc(1);
    cyc(3);
    chk("wd irq", 16'h0001, 16'(irqs > 0));
    chk("wd wake", 16'h0001, 16'(wakes > 0));
    chk("wd cpu reset", 16'h0001, 16'(pcs > 0));
    irqs = 0;
    for (int i = 0; i < 30; i++)
    begin
      i_wd_ctrl.kick = 1'b1;
      cyc(1);
      i_wd_ctrl.kick = 1'b0;
      cyc(9);
    end
    chk("wd kicked", 16'h0000, 16'(irqs));
    i_wd_ctrl.enable = 1'b0;
    cyc(4);
    irqs = 0;
    wakes = 0;
    cyc(500);
    chk("wd off", 16'h0000, 16'(irqs + wakes));
    // Internal divider: one tick per 3051 clocks, so a limit of 1 fires once
    i_use_ext_slow_clk = 1'b0;
    i_wd_ctrl.limit = 16'h0001;
    i_wd_ctrl.enable = 1'b1;
    irqs = 0;
    for (int i = 0; i < 3100 && irqs == 0; i++)
      cyc(1);
    cyc(20);
    chk("wd internal tick", 16'h0001, 16'(irqs));
    $display("watchdog test done");
    wrap_up();
  end
endmodule
bind brw_boot_ctrl brw_boot_ctrl_assertions u_chk (.i_sys_clk, .i_rst, .i_hard_reset_n,
  .i_boot_select_pins, .i_receiver_reset, .i_soft_cpu_reset, .i_soft_device_reset, .i_load_stat,
  .i_wd_ctrl, .o_boot_src, .o_load_start, .o_cpu_run, .o_pc_clear, .o_fw_invalid, .o_io_hiz,
  .o_receiver_core_reset, .o_wd_irq, .o_wd_wake);
